// File: src/lcd_instr_ctrl.sv
// instruction decoder, busy timing, reset sequences and key readback
module lcd_instr_ctrl #(
  parameter int POR_CYC = lcd_pkg::POR_CYC,
  parameter int RST_LOW_CYC = lcd_pkg::RST_LOW_CYC,
  parameter int RST_BUSY_CYC = lcd_pkg::RST_BUSY_CYC,
  parameter int CLR_CYC = lcd_pkg::CLR_CYC,
  parameter int WR_CYC = lcd_pkg::WR_CYC,
  parameter int BLINK_CYC = lcd_pkg::BLINK_CYC,
  parameter logic [1:0] OWN_SEL = lcd_pkg::SEL_MASTER
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // register port
  input wire logic [1:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  // reset pin and busy
  input wire logic RESET_PIN_N_I,
  output logic BUSY_O,
  // key matrix
  input wire logic [3:0] KEY_RETURN_N_I,
  output logic [7:0] SCAN_LINE_N_O,
  output logic KEY_PULLUP_EN_O,
  output logic KEY_REQ_O,
  // segment drive
  output logic [70:0] SEG_NONSEL_O,
  // display settings and timing
  output lcd_pkg::disp_cfg_s CFG_O,
  output logic BLINK_PHASE_O,
  input wire logic [3:0] DISP_POS_I,
  output logic SPACE_GAP_O,
  // text RAM read port
  input wire logic [3:0] TEXT_RADDR_I,
  output logic [7:0] TEXT_RDATA_O,
  // icon and pattern RAM write port
  output lcd_pkg::ram_wr_s RAM_WR_O
);
  logic [15:0] instruction_hold_reg_r;
  logic [7:0] data_hold_reg_r;
  logic exec_r;
  logic [5:0] op;
  logic [19:0] busy_cnt_r;
  logic busy_flag;
  logic [17:0] low_cnt_r;
  logic pin_armed_r;
  logic pin_rel;
  logic por_pend_r;
  logic init_go;
  logic instr_go;
  logic clr_act_r;
  logic [3:0] clr_idx_r;
  logic [4:0] address_counter_r;
  logic inc_r;
  logic eshift_r;
  logic cg_sel_r;
  logic [7:0] cg_addr_r;
  lcd_pkg::disp_cfg_s cfg_r;
  logic scan_on_r;
  logic key_pend_r;
  logic [15:0] key_word_r;
  lcd_pkg::key_val_s key_val;
  logic do_clr;
  logic is_write;
  logic is_text_wr;
  logic is_icon_wr;
  logic tr_we;
  logic [3:0] tr_waddr;
  logic [7:0] tr_wdata;
  logic [7:0] ac_wr_step;
  logic [7:0] ac_sh_step;
  logic [7:0] cg_step;
  logic [7:0] ds_cmd_step;
  logic [7:0] ds_wr_step;
  logic [26:0] blink_cnt_r;
  logic blink_r;

  function automatic logic [7:0] step8(input logic [7:0] a, input logic up);
    step8 = up ? 8'(a + 8'h01) : 8'(a - 8'h01);
  endfunction

  function automatic logic exec_is(input logic ex, input logic [5:0] o, input logic [5:0] c);
    exec_is = ex && o == c;
  endfunction

  // reset pin: armed only after a long enough low, acted on at release
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      low_cnt_r <= 18'h00000;
      pin_armed_r <= 1'b0;
    end else if (!RESET_PIN_N_I) begin
      if (low_cnt_r == 18'(RST_LOW_CYC)) begin
        pin_armed_r <= 1'b1;
      end else begin
        low_cnt_r <= 18'(low_cnt_r + 18'h00001);
      end
    end else begin
      low_cnt_r <= 18'h00000;
      pin_armed_r <= 1'b0;
    end
  end

  assign pin_rel = pin_armed_r & RESET_PIN_N_I;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      por_pend_r <= 1'b1;
    end else begin
      por_pend_r <= 1'b0;
    end
  end

  assign init_go = por_pend_r | pin_rel;

  // instruction capture; other device's words and words sent while busy are dropped
  assign instr_go = WR_I && ADDR_I == lcd_pkg::ADDR_INSTR && WDATA_I[15:14] == OWN_SEL
    && !busy_flag;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      instruction_hold_reg_r <= 16'h0000;
      data_hold_reg_r <= 8'h00;
      exec_r <= 1'b0;
    end else begin
      exec_r <= instr_go;
      if (instr_go) begin
        instruction_hold_reg_r <= WDATA_I;
        data_hold_reg_r <= WDATA_I[7:0];
      end
    end
  end

  assign op = instruction_hold_reg_r[13:8];
  assign do_clr = exec_is(exec_r, op, lcd_pkg::OP_CLEAR);
  assign is_write = exec_is(exec_r, op, lcd_pkg::OP_WRITE);
  assign is_text_wr = is_write && !cg_sel_r && address_counter_r < lcd_pkg::TEXT_END;
  assign is_icon_wr = is_write && !cg_sel_r && address_counter_r >= lcd_pkg::ICON_BASE
    && address_counter_r <= lcd_pkg::ICON_LAST;

  assign busy_flag = exec_r | clr_act_r | pin_armed_r | por_pend_r | (busy_cnt_r != 20'h00000);
  assign BUSY_O = busy_flag;

  // busy timer; loaded in the execution cycle, so counts start two cycles after the instruction is taken
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_cnt_r <= 20'h00000;
    end else if (por_pend_r) begin
      busy_cnt_r <= 20'(POR_CYC);
    end else if (pin_rel) begin
      busy_cnt_r <= 20'(RST_BUSY_CYC);
    end else if (do_clr) begin
      busy_cnt_r <= 20'(CLR_CYC);
    end else if (is_write) begin
      busy_cnt_r <= 20'(WR_CYC);
    end else if (busy_cnt_r != 20'h00000) begin
      busy_cnt_r <= 20'(busy_cnt_r - 20'h00001);
    end
  end

  // clear engine: one text location per cycle, hidden under the busy time
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clr_act_r <= 1'b0;
      clr_idx_r <= 4'h0;
    end else if (init_go || do_clr) begin
      clr_act_r <= 1'b1;
      clr_idx_r <= 4'h0;
    end else if (clr_act_r) begin
      if (clr_idx_r == 4'(lcd_pkg::TEXT_DEPTH - 1)) clr_act_r <= 1'b0;
      clr_idx_r <= 4'(clr_idx_r + 4'h1);
    end
  end

  assign tr_we = clr_act_r | is_text_wr;
  assign tr_waddr = clr_act_r ? clr_idx_r : address_counter_r[3:0];
  assign tr_wdata = clr_act_r ? lcd_pkg::SPACE_CODE : data_hold_reg_r;

  text_ram u_text_ram (
    .clk_i(REF_CLK_I),
    .we_i(tr_we),
    .waddr_i(tr_waddr),
    .wdata_i(tr_wdata),
    .raddr_i(TEXT_RADDR_I),
    .rdata_o(TEXT_RDATA_O)
  );

  assign ac_wr_step = step8({3'h0, address_counter_r}, inc_r);
  assign ac_sh_step = step8({3'h0, address_counter_r}, instruction_hold_reg_r[0]);
  assign cg_step = step8(cg_addr_r, inc_r);

  // address counter, entry mode and RAM target
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      address_counter_r <= 5'h00;
      inc_r <= 1'b1;
      eshift_r <= 1'b0;
      cg_sel_r <= 1'b0;
      cg_addr_r <= 8'h00;
    end else if (init_go) begin
      address_counter_r <= 5'h00;
      inc_r <= 1'b1;
      eshift_r <= 1'b0;
      cg_sel_r <= 1'b0;
    end else if (do_clr) begin
      address_counter_r <= 5'h00;
      inc_r <= 1'b1;
      cg_sel_r <= 1'b0;
    end else if (exec_is(exec_r, op, lcd_pkg::OP_HOME)) begin
      address_counter_r <= 5'h00;
      cg_sel_r <= 1'b0;
    end else if (exec_is(exec_r, op, lcd_pkg::OP_ENTRY)) begin
      inc_r <= instruction_hold_reg_r[1];
      eshift_r <= instruction_hold_reg_r[0];
    end else if (exec_is(exec_r, op, lcd_pkg::OP_ASHIFT)) begin
      address_counter_r <= ac_sh_step[4:0];
    end else if (exec_is(exec_r, op, lcd_pkg::OP_TADDR)) begin
      address_counter_r <= instruction_hold_reg_r[4:0];
      cg_sel_r <= 1'b0;
    end else if (exec_is(exec_r, op, lcd_pkg::OP_PADDR)) begin
      cg_addr_r <= instruction_hold_reg_r[7:0];
      cg_sel_r <= 1'b1;
    end else if (is_write) begin
      if (cg_sel_r) begin
        cg_addr_r <= cg_step;
      end else begin
        address_counter_r <= ac_wr_step[4:0];
      end
    end
  end

  assign ds_cmd_step = step8({4'h0, cfg_r.dshift}, instruction_hold_reg_r[0]);
  assign ds_wr_step = step8({4'h0, cfg_r.dshift}, inc_r);

  // display settings and key scan switch
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_r <= '0;
      scan_on_r <= 1'b0;
    end else if (init_go) begin
      cfg_r <= '0;
      scan_on_r <= 1'b0;
    end else if (exec_is(exec_r, op, lcd_pkg::OP_DCTRL)) begin
      cfg_r.disp_on <= instruction_hold_reg_r[2];
      cfg_r.icon_on <= instruction_hold_reg_r[1];
      cfg_r.blink <= instruction_hold_reg_r[0];
    end else if (exec_is(exec_r, op, lcd_pkg::OP_HOME)) begin
      cfg_r.dshift <= 4'h0;
    end else if (exec_is(exec_r, op, lcd_pkg::OP_DSHIFT)) begin
      cfg_r.dshift <= ds_cmd_step[3:0];
    end else if (exec_is(exec_r, op, lcd_pkg::OP_PORT)) begin
      cfg_r.port <= instruction_hold_reg_r[3:0];
    end else if (exec_is(exec_r, op, lcd_pkg::OP_CONTRAST)) begin
      cfg_r.contrast <= instruction_hold_reg_r[3:0];
    end else if (exec_is(exec_r, op, lcd_pkg::OP_DOT)) begin
      cfg_r.dot <= instruction_hold_reg_r[2:0];
    end else if (exec_is(exec_r, op, lcd_pkg::OP_MODE)) begin
      scan_on_r <= instruction_hold_reg_r[1];
      cfg_r.pwr_down <= instruction_hold_reg_r[0];
    end else if (is_text_wr && eshift_r) begin
      cfg_r.dshift <= ds_wr_step[3:0];
    end
  end

  assign CFG_O = cfg_r;

  // icon and pattern writes leave through a registered port
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RAM_WR_O <= '0;
    end else begin
      RAM_WR_O.we <= is_icon_wr | (is_write & cg_sel_r);
      RAM_WR_O.pattern <= cg_sel_r;
      RAM_WR_O.addr <= cg_sel_r ? cg_addr_r : {3'h0, address_counter_r};
      RAM_WR_O.data <= data_hold_reg_r;
    end
  end

  key_scan u_key_scan (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .scan_on_i(scan_on_r),
    .hold_i(key_pend_r),
    .ret_n_i(KEY_RETURN_N_I),
    .scan_n_o(SCAN_LINE_N_O),
    .pullup_en_o(KEY_PULLUP_EN_O),
    .seg_nonsel_o(SEG_NONSEL_O),
    .key_req_o(KEY_REQ_O),
    .key_o(key_val)
  );

  // key read: word captured at execution, kept until software reads it
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      key_pend_r <= 1'b0;
      key_word_r <= 16'h0000;
    end else if (exec_is(exec_r, op, lcd_pkg::OP_KEYRD)) begin
      key_pend_r <= 1'b1;
      key_word_r <= {OWN_SEL, lcd_pkg::OP_KEYRD, key_val};
    end else if (RD_I && ADDR_I == lcd_pkg::ADDR_INSTR) begin
      key_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 16'h0000;
    end else if (RD_I) begin
      case (ADDR_I)
        lcd_pkg::ADDR_INSTR: RDATA_O <= key_word_r;
        lcd_pkg::ADDR_STATUS: RDATA_O <= {13'h0000, key_pend_r, scan_on_r, busy_flag};
        lcd_pkg::ADDR_AC: RDATA_O <= {cg_addr_r, 3'h0, address_counter_r};
        default: RDATA_O <= 16'h0000;
      endcase
    end else begin
      RDATA_O <= 16'h0000;
    end
  end

  // own blink time base; a cascaded partner runs its own, so phases drift
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      blink_cnt_r <= 27'h0000000;
      blink_r <= 1'b0;
    end else if (blink_cnt_r == 27'(BLINK_CYC - 1)) begin
      blink_cnt_r <= 27'h0000000;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= 27'(blink_cnt_r + 27'h0000001);
    end
  end

  assign BLINK_PHASE_O = blink_r & cfg_r.blink;

  // scroll gap only while dot-shifted, never after the last character
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SPACE_GAP_O <= 1'b0;
    end else begin
      SPACE_GAP_O <= cfg_r.dot != 3'h0 && DISP_POS_I < lcd_pkg::LAST_GAP_POS;
    end
  end
endmodule // lcd_instr_ctrl

// File: src/lcd_pkg.sv
// shared constants and carrier types for the instruction front end
package lcd_pkg;
  // clock rate (200 MHz) and timing derived from a nominal 145 kHz oscillator
  localparam int CLK_MHZ = 200;
  localparam int POR_TIME_US = 1500;      // 1.5 ms
  localparam int RST_LOW_TIME_US = 1200;  // 1.2 ms
  localparam int RST_BUSY_TIME_US = 250;
  localparam int CLR_TIME_NS = 234480;    // 234.48 us
  localparam int WR_TIME_NS = 41380;      // 41.38 us
  localparam int BLINK_TIME_MS = 500;
  localparam int POR_CYC = POR_TIME_US * CLK_MHZ;
  localparam int RST_LOW_CYC = RST_LOW_TIME_US * CLK_MHZ;
  localparam int RST_BUSY_CYC = RST_BUSY_TIME_US * CLK_MHZ;
  localparam int CLR_CYC = (CLR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC = (WR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int BLINK_CYC = BLINK_TIME_MS * CLK_MHZ * 1000;
  // key scan timing in clock cycles
  localparam int SCAN_PULSE_CYC = 256;
  localparam int SCAN_GAP_CYC = 2048;
  localparam int KEY_SAMPLE_CYC = SCAN_PULSE_CYC * 3 / 4;
  localparam int KEY_LOAD_DLY = 2;
  // target select codes in bits 15:14
  localparam logic [1:0] SEL_MASTER = 2'h2;
  localparam logic [1:0] SEL_SLAVE = 2'h1;
  // operation codes in bits 13:8
  localparam logic [5:0] OP_TEST = 6'h1F;
  localparam logic [5:0] OP_CLEAR = 6'h19;
  localparam logic [5:0] OP_HOME = 6'h11;
  localparam logic [5:0] OP_ENTRY = 6'h08;
  localparam logic [5:0] OP_DCTRL = 6'h09;
  localparam logic [5:0] OP_ASHIFT = 6'h12;
  localparam logic [5:0] OP_DSHIFT = 6'h0A;
  localparam logic [5:0] OP_PORT = 6'h0B;
  localparam logic [5:0] OP_CONTRAST = 6'h0C;
  localparam logic [5:0] OP_DOT = 6'h0D;
  localparam logic [5:0] OP_MODE = 6'h0E;
  localparam logic [5:0] OP_TADDR = 6'h13;
  localparam logic [5:0] OP_PADDR = 6'h10;
  localparam logic [5:0] OP_WRITE = 6'h18;
  localparam logic [5:0] OP_KEYRD = 6'h27;
  // register port offsets
  localparam logic [1:0] ADDR_INSTR = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_AC = 2'h2;
  // memory map of the address counter
  localparam int TEXT_DEPTH = 14;
  localparam logic [4:0] TEXT_END = 5'h0E;
  localparam logic [4:0] ICON_BASE = 5'h10;
  localparam logic [4:0] ICON_LAST = 5'h1B;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [3:0] LAST_GAP_POS = 4'hB;
  localparam int SEG_COUNT = 71;
  localparam int SCAN_LINES = 8;

  typedef struct packed {
    logic disp_on;
    logic icon_on;
    logic blink;
    logic pwr_down;
    logic [3:0] port;
    logic [3:0] contrast;
    logic [2:0] dot;
    logic [3:0] dshift;
  } disp_cfg_s;

  typedef struct packed {
    logic we;
    logic pattern;
    logic [7:0] addr;
    logic [7:0] data;
  } ram_wr_s;

  typedef struct packed {
    logic [3:0] ret;
    logic zero;
    logic [2:0] line;
  } key_val_s;
endpackage

// File: src/text_ram.sv
// text RAM: one write port, one registered read port
module text_ram (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [3:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [lcd_pkg::TEXT_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i && waddr_i < 4'(lcd_pkg::TEXT_DEPTH)) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // out of range reads return zero rather than an undefined word
  always_ff @(posedge clk_i) begin
    if (raddr_i < 4'(lcd_pkg::TEXT_DEPTH)) begin
      rdata_o <= mem[raddr_i];
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // text_ram

// File: src/key_scan.sv
// key matrix scanner: 8 scan lines, 4 return lines, key holding register
module key_scan (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scan_on_i,
  input wire logic hold_i,
  input wire logic [3:0] ret_n_i,
  output logic [7:0] scan_n_o,
  output logic pullup_en_o,
  output logic [70:0] seg_nonsel_o,
  output logic key_req_o,
  output lcd_pkg::key_val_s key_o
);
  typedef enum logic [1:0] {SC_DISP = 2'b00, SC_SCAN = 2'b01, SC_LOAD = 2'b10} sc_e;
  sc_e st_r;
  logic [11:0] cnt_r;
  logic [2:0] line_r;
  logic found_r;
  lcd_pkg::key_val_s cap_r;
  logic sample;

  assign sample = st_r == SC_SCAN && cnt_r == 12'(lcd_pkg::KEY_SAMPLE_CYC) && scan_on_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= SC_DISP;
      cnt_r <= 12'h000;
      line_r <= 3'h0;
    end else begin
      cnt_r <= 12'(cnt_r + 12'h001);
      case (st_r)
        SC_DISP: if (cnt_r == 12'(lcd_pkg::SCAN_GAP_CYC - 1)) begin
          st_r <= SC_SCAN;
          cnt_r <= 12'h000;
          line_r <= 3'h0;
        end
        SC_SCAN: if (cnt_r == 12'(lcd_pkg::SCAN_PULSE_CYC - 1)) begin
          cnt_r <= 12'h000;
          line_r <= 3'(line_r + 3'h1);
          if (line_r == 3'(lcd_pkg::SCAN_LINES - 1)) st_r <= SC_LOAD;
        end
        SC_LOAD: if (cnt_r == 12'(lcd_pkg::KEY_LOAD_DLY - 1)) begin
          st_r <= SC_DISP;
          cnt_r <= 12'h000;
        end
        default: st_r <= SC_DISP;
      endcase
    end
  end

  // the last line with a press wins; several returns on one line stay exact
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      found_r <= 1'b0;
      cap_r <= '0;
    end else if (st_r == SC_DISP) begin
      found_r <= 1'b0;
    end else if (sample && ret_n_i != 4'hF) begin
      found_r <= 1'b1;
      cap_r <= '{ret: ~ret_n_i, zero: 1'b0, line: line_r};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_o <= '0;
    end else if (st_r == SC_LOAD && cnt_r == 12'(lcd_pkg::KEY_LOAD_DLY - 1) && !hold_i) begin
      key_o <= found_r ? cap_r : '0;
    end
  end

  // request is cleared at the end of the first cycle of the next scan, so it is low from its second cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_req_o <= 1'b0;
    end else if (sample && ret_n_i != 4'hF) begin
      key_req_o <= 1'b1;
    end else if (st_r == SC_SCAN && cnt_r == 12'h000 && line_r == 3'h0) begin
      key_req_o <= 1'b0;
    end
  end

  always_comb begin
    scan_n_o = 8'hFF;
    pullup_en_o = 1'b0;
    seg_nonsel_o = '0;
    if (st_r == SC_SCAN) begin
      if (scan_on_i) begin
        scan_n_o = ~(8'h01 << line_r);
        pullup_en_o = 1'b1;
        seg_nonsel_o = {{(lcd_pkg::SEG_COUNT - 8){1'b1}}, 8'h00};
      end else begin
        seg_nonsel_o = '1;
      end
    end
  end
endmodule // key_scan

// File: tb/key_matrix_model.sv
// key matrix partner: one switch between a scan line and a return line
module key_matrix_model (
  // clock
  input wire logic clk_i,
  // scan side
  input wire logic pullup_en_i,
  input wire logic [7:0] scan_n_i,
  // switch under test
  input wire logic press_i,
  input wire logic [2:0] line_i,
  input wire logic [1:0] ret_i,
  // return lines
  output logic [3:0] ret_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog_r = 1'b0;
  always @(posedge clk_i) tog_r <= ~tog_r;
  // unpulled returns float, so show a changing level rather than a steady high
  always_comb begin
    ret_n_o = {4{tog_r}};
    if (pullup_en_i) begin
      ret_n_o = 4'hF;
      if (press_i && !scan_n_i[line_i]) ret_n_o[ret_i] = 1'b0;
    end
  end
endmodule // key_matrix_model

// File: tb/lcd_instr_ctrl_chk.sv
// port assertions for the instruction front end
module lcd_instr_ctrl_chk #(
  parameter int RST_LOW_CYC = 20,
  parameter int CLR_CYC = 30,
  parameter int WR_CYC = 5,
  parameter logic [1:0] OWN_SEL = 2'h2
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [1:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic RESET_PIN_N_I,
  input wire logic BUSY_O,
  input wire logic [7:0] SCAN_LINE_N_O,
  input wire logic KEY_REQ_O,
  input wire logic [70:0] SEG_NONSEL_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic [19:0] run_r;
  logic [19:0] low_r;
  logic [1:0] kind_r;
  logic go;
  assign go = WR_I && ADDR_I == 2'h0 && !BUSY_O;
  // busy run length and reset pin low time
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      run_r <= 20'h0;
      low_r <= 20'h0;
    end else begin
      run_r <= BUSY_O ? run_r + 20'h1 : 20'h0;
      low_r <= RESET_PIN_N_I ? 20'h0 : low_r + 20'h1;
    end
  end
  // kind of the last accepted instruction; a pin reset voids it
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) kind_r <= 2'h0;
    else if (!RESET_PIN_N_I) kind_r <= 2'h0;
    else if (go && WDATA_I[15:14] == OWN_SEL)
      kind_r <= WDATA_I[13:8] == lcd_pkg::OP_WRITE ? 2'h1 :
                WDATA_I[13:8] == lcd_pkg::OP_CLEAR ? 2'h2 : 2'h3;
  end
  AST_WR_TIME: assert property ($fell(BUSY_O) && kind_r == 2'h1 |-> run_r == 20'(WR_CYC + 1))
    else $error("write busy time wrong");
  AST_CLR_TIME: assert property ($fell(BUSY_O) && kind_r == 2'h2 |-> run_r == 20'(CLR_CYC + 1))
    else $error("clear busy time wrong");
  AST_ZERO_TIME: assert property ($fell(BUSY_O) && kind_r == 2'h3 |-> run_r == 20'h1)
    else $error("immediate instruction kept busy");
  AST_FOREIGN: assert property (go && WDATA_I[15:14] != OWN_SEL |=> !BUSY_O)
    else $error("foreign instruction acted on");
  AST_PIN_ARM: assert property ($rose(RESET_PIN_N_I) && low_r > 20'(RST_LOW_CYC) |-> BUSY_O[*4])
    else $error("long reset pin low gave no busy");
  AST_PIN_SHORT: assert property ($rose(RESET_PIN_N_I) && low_r < 20'(RST_LOW_CYC) && !BUSY_O
    |=> (!BUSY_O)[*4])
    else $error("short reset pin low acted on");
  AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data outside read slot");
  AST_ONE_LINE: assert property ($countones(~SCAN_LINE_N_O) <= 1)
    else $error("several scan lines low");
  AST_SEG_NONSEL: assert property (SCAN_LINE_N_O != 8'hFF |-> &SEG_NONSEL_O[70:8])
    else $error("segment not at non-select in scan");
  AST_REQ_SRC: assert property ($rose(KEY_REQ_O) |-> $past(SCAN_LINE_N_O) != 8'hFF)
    else $error("key request outside scan");
  AST_REQ_CLR: assert property ($fell(SCAN_LINE_N_O[0]) |-> ##[0:2] !KEY_REQ_O)
    else $error("key request not cleared");
  cover property (go && WDATA_I[13:8] == lcd_pkg::OP_CLEAR);
  cover property ($rose(KEY_REQ_O));
  cover property ($rose(RESET_PIN_N_I) && low_r > 20'(RST_LOW_CYC));
endmodule // lcd_instr_ctrl_chk

bind lcd_instr_ctrl lcd_instr_ctrl_chk #(
  .RST_LOW_CYC(RST_LOW_CYC), .CLR_CYC(CLR_CYC), .WR_CYC(WR_CYC), .OWN_SEL(OWN_SEL)
) i_lcd_instr_ctrl_chk (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .RESET_PIN_N_I(RESET_PIN_N_I),
  .BUSY_O(BUSY_O), .SCAN_LINE_N_O(SCAN_LINE_N_O), .KEY_REQ_O(KEY_REQ_O),
  .SEG_NONSEL_O(SEG_NONSEL_O)
);

// File: tb/lcd_instruction_keyscan_ctrl_tb.sv
// self-checking bench for the instruction front end
module lcd_instruction_keyscan_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts keep the run small
  localparam int POR = 40;
  localparam int RLOW = 20;
  localparam int RBUSY = 30;
  logic clk, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, pin_n = 1'b1, press = 1'b0;
  logic busy, pull, req, gap, blk, bad = 1'b0;
  logic [1:0] addr = 2'h0, ret = 2'h0;
  logic [2:0] line = 3'h0;
  logic [3:0] pos = 4'h0, raddr = 4'h0, ret_n;
  logic [7:0] scan_n, rtxt;
  logic [15:0] wdata = 16'h0, rdata, d;
  logic [70:0] seg;
  logic [7:0] txtv [4];
  lcd_pkg::disp_cfg_s cfg;
  lcd_pkg::ram_wr_s ramwr, seen_wr;
  int failures = 0;
  int num_checks = 0;
  int cnt, i;
  logic [5:0] ops [9] = '{lcd_pkg::OP_TEST, lcd_pkg::OP_HOME, lcd_pkg::OP_ENTRY,
    lcd_pkg::OP_ASHIFT, lcd_pkg::OP_DSHIFT, lcd_pkg::OP_PORT, lcd_pkg::OP_CONTRAST,
    lcd_pkg::OP_DOT, lcd_pkg::OP_DCTRL};
  logic [7:0] dat [9] = '{8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h0A, 8'h05, 8'h03, 8'h05};

  lcd_instr_ctrl #(.POR_CYC(POR), .RST_LOW_CYC(RLOW), .RST_BUSY_CYC(RBUSY), .CLR_CYC(30),
    .WR_CYC(5), .BLINK_CYC(50), .OWN_SEL(lcd_pkg::SEL_MASTER)) i_lcd_instr_ctrl (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(bus_wr),
    .RD_I(bus_rd), .RDATA_O(rdata), .RESET_PIN_N_I(pin_n), .BUSY_O(busy),
    .KEY_RETURN_N_I(ret_n), .SCAN_LINE_N_O(scan_n), .KEY_PULLUP_EN_O(pull), .KEY_REQ_O(req),
    .SEG_NONSEL_O(seg), .CFG_O(cfg), .BLINK_PHASE_O(blk), .DISP_POS_I(pos), .SPACE_GAP_O(gap),
    .TEXT_RADDR_I(raddr), .TEXT_RDATA_O(rtxt), .RAM_WR_O(ramwr));
  key_matrix_model i_key_matrix_model (.clk_i(clk), .pullup_en_i(pull), .scan_n_i(scan_n),
    .press_i(press), .line_i(line), .ret_i(ret), .ret_n_o(ret_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (ramwr.we === 1'b1) seen_wr <= ramwr;

  task report_and_stop();
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic bit cond(input int s);
    case (s)
      0: return busy === 1'b0;
      1: return req === 1'b1;
      2: return scan_n === 8'hFF;
      default: return scan_n[0] === 1'b0;
    endcase
  endfunction
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // the #1 lets the launching edge land before the condition is judged
  task wt(input int s, input int lim);
    cnt = 0;
    #1;
    while (!cond(s)) begin
      tick(1);
      cnt++;
      if (cnt > lim) begin
        failures++;
        report_and_stop();
      end
    end
  endtask
  task put(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    bus_wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task get(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk);
    bus_rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 v = rdata;
  endtask
  task ins(input logic [5:0] op, input logic [7:0] v);
    wt(0, 1000);
    put(2'h0, {lcd_pkg::SEL_MASTER, op, v});
  endtask
  task txt(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    raddr <= a;
    tick(2);
    chk({8'h00, rtxt}, {8'h00, e});
  endtask
  function automatic logic [15:0] key_word(input logic on, input logic [2:0] l,
    input logic [1:0] r);
    key_word = {lcd_pkg::SEL_MASTER, lcd_pkg::OP_KEYRD, 8'h00};
    if (on) key_word[7:0] = {4'h1 << r, 1'b0, l};
  endfunction
  // one switch at a time: rollover across scan lines is not trusted
  task key_try(input logic [2:0] l, input logic [1:0] r);
    line <= l;
    ret <= r;
    press <= 1'b1;
    wt(1, 12000);
    wt(2, 3000);
    tick(4);
    ins(lcd_pkg::OP_KEYRD, 8'h00);
    wt(0, 100);
    get(2'h0, d);
    chk(d, key_word(1'b1, l, r));
    press <= 1'b0;
    wt(3, 6000);
    wt(2, 3000);
    tick(4);
    ins(lcd_pkg::OP_KEYRD, 8'h00);
    wt(0, 100);
    get(2'h0, d);
    chk(d, key_word(1'b0, l, r));
  endtask

  initial begin
    void'($urandom(34));
    repeat (3) @(posedge clk);
    chk({15'h0, busy}, 16'h1);
    rst_n <= 1'b1;
    wt(0, 1000);
    chk(16'(cnt >= POR && cnt <= POR + 4), 16'h1);
    get(2'h1, d);
    chk(d & 16'h7, 16'h0);
    ins(lcd_pkg::OP_TADDR, 8'h00);
    for (i = 0; i < 4; i++) begin
      txtv[i] = 8'($urandom);
      ins(lcd_pkg::OP_WRITE, txtv[i]);
    end
    wt(0, 100);
    for (i = 0; i < 4; i++) txt(4'(i), txtv[i]);
    get(2'h2, d);
    chk(d & 16'h1F, 16'h4);
    ins(lcd_pkg::OP_CLEAR, 8'h00);
    wt(0, 1000);
    for (i = 0; i < 14; i++) txt(4'(i), lcd_pkg::SPACE_CODE);
    get(2'h2, d);
    chk(d & 16'h1F, 16'h0);
    ins(lcd_pkg::OP_PADDR, 8'h08);
    ins(lcd_pkg::OP_WRITE, 8'h15);
    wt(0, 100);
    chk({seen_wr.addr, seen_wr.data}, 16'h0815);
    for (i = 0; i < 9; i++) ins(ops[i], dat[i]);
    wt(0, 100);
    chk({cfg.port, cfg.contrast, 1'b0, cfg.dot, 3'h0, cfg.disp_on}, 16'hA531);
    put(2'h0, {lcd_pkg::SEL_SLAVE, lcd_pkg::OP_DCTRL, 8'h00});
    tick(2);
    chk({15'h0, cfg.disp_on}, 16'h1);
    tick(50);
    d[0] = blk;
    tick(50);
    chk({15'h0, blk}, {15'h0, ~d[0]});
    for (i = 0; i < 12; i++) begin
      pos <= 4'(i);
      tick(3);
      chk({15'h0, gap}, 16'(i < 11));
    end
    ins(lcd_pkg::OP_TADDR, 8'h0C);
    ins(lcd_pkg::OP_WRITE, 8'h41);
    ins(lcd_pkg::OP_WRITE, 8'h42);
    txt(4'hC, 8'h41);
    ins(lcd_pkg::OP_MODE, 8'h02);
    wt(0, 100);
    get(2'h1, d);
    chk(d & 16'h7, 16'h2);
    key_try(3'h0, 2'h0);
    key_try(3'h7, 2'h3);
    key_try(3'h2, 2'h2);
    key_try(3'($urandom), 2'($urandom));
    ins(lcd_pkg::OP_MODE, 8'h00);
    press <= 1'b1;
    cnt = 0;
    for (i = 0; i < 5000; i++) begin
      tick(1);
      if (req !== 1'b0 || pull !== 1'b0 || (seg !== '0 && seg !== '1)) bad = 1'b1;
      if (seg === '1) cnt++;
    end
    chk({15'h0, bad}, 16'h0);
    chk(16'(cnt >= lcd_pkg::SCAN_PULSE_CYC * lcd_pkg::SCAN_LINES), 16'h1);
    press <= 1'b0;
    get(2'h1, d);
    chk(d & 16'h7, 16'h0);
    pin_n <= 1'b0;
    tick(10);
    pin_n <= 1'b1;
    tick(3);
    chk({15'h0, busy}, 16'h0);
    pin_n <= 1'b0;
    tick(RLOW + 5);
    pin_n <= 1'b1;
    wt(0, 1000);
    chk(16'(cnt >= RBUSY && cnt <= RBUSY + 3), 16'h1);
    chk({cfg.port, cfg.contrast, 1'b0, cfg.dot, 3'h0, cfg.disp_on}, 16'h0);
    txt(4'hC, lcd_pkg::SPACE_CODE);
    report_and_stop();
  end
endmodule // lcd_instruction_keyscan_ctrl_tb
